// >>> design/atp_pkg.sv
package atp_pkg;

    // =========================================================
    // widths
    localparam int OP_W   = 10;
    localparam int NIB_W  = 4;
    localparam int BYTE_W = 8;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int IDX_W  = 4;
    localparam int CNT_W  = 8;

    // =========================================================
    // transfer opcodes with printed codes
    localparam logic [OP_W-1:0] LOAD_TIMER3_RELOAD_OP  = 10'h23B;
    localparam logic [OP_W-1:0] LOAD_CLOCK_GEN_OP      = 10'h209;
    localparam logic [OP_W-1:0] LOAD_SERIAL_SHIFT_OP   = 10'h238;
    localparam logic [OP_W-1:0] LOAD_INT_CTRL_ONE_OP   = 10'h03F;
    localparam logic [OP_W-1:0] LOAD_TIMER_CTRL_ONE_OP = 10'h20E;
    localparam logic [OP_W-1:0] LOAD_TIMER_CTRL_TWO_OP = 10'h20F;
    localparam logic [OP_W-1:0] LOAD_TIMER_CTRL_FOUR_OP = 10'h211;
    localparam logic [OP_W-1:0] LOAD_TIMER_CTRL_SIX_OP = 10'h213;

    // =========================================================
    // target indexes, also register order on the bus
    localparam int T_TIMER3_RELOAD = 0;
    localparam int T_CLOCK_GEN     = 1;
    localparam int T_SERIAL_SHIFT  = 2;
    localparam int T_INT_CTRL_ONE  = 3;
    localparam int T_INT_CTRL_TWO  = 4;
    localparam int T_TIMER_CTRL_1  = 5;
    localparam int T_TIMER_CTRL_2  = 6;
    localparam int T_TIMER_CTRL_3  = 7;
    localparam int T_TIMER_CTRL_4  = 8;
    localparam int T_TIMER_CTRL_5  = 9;
    localparam int T_TIMER_CTRL_6  = 10;
    localparam int N_TGT           = 11;

    // =========================================================
    // register map
    localparam logic [ADDR_W-1:0] ADDR_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_TGT_BASE = 8'h08;
    localparam int                CTRL_EN_BIT   = 0;
    localparam int                STAT_CNT_LSB  = 8;
    localparam int                STAT_VLD_BIT  = 31;
    localparam logic              CTRL_EN_RST   = 1'b1;
    localparam logic [BYTE_W-1:0] TGT_RST       = 8'h00;

endpackage

// >>> design/atp_decode.sv
`timescale 1ns/100ps
module atp_decode
#(
    parameter logic [atp_pkg::OP_W-1:0] OP_INT_CTRL_TWO   = 10'h03E,
    parameter logic [atp_pkg::OP_W-1:0] OP_TIMER_CTRL_THR = 10'h210,
    parameter logic [atp_pkg::OP_W-1:0] OP_TIMER_CTRL_FIV = 10'h212
)
(
    input  wire logic [atp_pkg::OP_W-1:0]  instr_word,
    input  wire logic                      instr_valid,
    output logic      [atp_pkg::N_TGT-1:0] tgt_sel
);

    // =========================================================
    // opcode match
    function automatic logic hit(input logic [atp_pkg::OP_W-1:0] w, input logic [atp_pkg::OP_W-1:0] op);
        hit = (w == op);
    endfunction

    always_comb
    begin
        tgt_sel = '0;
        if (instr_valid)
        begin
            tgt_sel[atp_pkg::T_TIMER3_RELOAD] = hit(instr_word, atp_pkg::LOAD_TIMER3_RELOAD_OP);
            tgt_sel[atp_pkg::T_CLOCK_GEN]     = hit(instr_word, atp_pkg::LOAD_CLOCK_GEN_OP);
            tgt_sel[atp_pkg::T_SERIAL_SHIFT]  = hit(instr_word, atp_pkg::LOAD_SERIAL_SHIFT_OP);
            tgt_sel[atp_pkg::T_INT_CTRL_ONE]  = hit(instr_word, atp_pkg::LOAD_INT_CTRL_ONE_OP);
            tgt_sel[atp_pkg::T_INT_CTRL_TWO]  = hit(instr_word, OP_INT_CTRL_TWO);
            tgt_sel[atp_pkg::T_TIMER_CTRL_1]  = hit(instr_word, atp_pkg::LOAD_TIMER_CTRL_ONE_OP);
            tgt_sel[atp_pkg::T_TIMER_CTRL_2]  = hit(instr_word, atp_pkg::LOAD_TIMER_CTRL_TWO_OP);
            tgt_sel[atp_pkg::T_TIMER_CTRL_3]  = hit(instr_word, OP_TIMER_CTRL_THR);
            tgt_sel[atp_pkg::T_TIMER_CTRL_4]  = hit(instr_word, atp_pkg::LOAD_TIMER_CTRL_FOUR_OP);
            tgt_sel[atp_pkg::T_TIMER_CTRL_5]  = hit(instr_word, OP_TIMER_CTRL_FIV);
            tgt_sel[atp_pkg::T_TIMER_CTRL_6]  = hit(instr_word, atp_pkg::LOAD_TIMER_CTRL_SIX_OP);
        end
    end

endmodule

// >>> design/atp_xfer_top.sv
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
// Behaviour
// RULE_01: timer-3 reload op writes second nibble high, accumulator low.
// RULE_02: clock-generator op copies accumulator bit 0 only, one cycle.
// RULE_03: serial shift op writes second nibble to bits 7-4, accumulator 3-0.
// RULE_04: interrupt control one op copies accumulator, one cycle.
// RULE_05: interrupt control two op copies accumulator, one cycle.
// RULE_06: timer control one op copies accumulator, one cycle.
// RULE_07: timer control two op copies accumulator, one cycle.
// RULE_08: timer control three op copies accumulator, one cycle.
// RULE_09: timer control four op copies accumulator, one cycle.
// RULE_10: timer control five op copies accumulator, one cycle.
// RULE_11: timer control six op copies accumulator, one cycle.
// RULE_12: no carry change, no skip, sources left untouched.
module atp_xfer_top
#(
    parameter logic [atp_pkg::OP_W-1:0] OP_INT_CTRL_TWO   = 10'h03E,
    parameter logic [atp_pkg::OP_W-1:0] OP_TIMER_CTRL_THR = 10'h210,
    parameter logic [atp_pkg::OP_W-1:0] OP_TIMER_CTRL_FIV = 10'h212
)
(
    input  wire logic                        mclk,
    input  wire logic                        rstn,
    input  wire logic [atp_pkg::OP_W-1:0]    instr_word,
    input  wire logic                        instr_valid,
    input  wire logic [atp_pkg::NIB_W-1:0]   acc,
    input  wire logic [atp_pkg::NIB_W-1:0]   breg,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [atp_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [atp_pkg::DATA_W-1:0]  pwdata,
    output logic      [atp_pkg::DATA_W-1:0]  prdata,
    output logic                             pready,
    output logic                             pslverr,
    output logic      [atp_pkg::BYTE_W-1:0]  timer_three_reload,
    output logic                             clock_gen_ctrl,
    output logic      [atp_pkg::BYTE_W-1:0]  serial_shift,
    output logic      [atp_pkg::NIB_W-1:0]   int_ctrl_one,
    output logic      [atp_pkg::NIB_W-1:0]   int_ctrl_two,
    output logic      [atp_pkg::NIB_W-1:0]   timer_ctrl_one,
    output logic      [atp_pkg::NIB_W-1:0]   timer_ctrl_two,
    output logic      [atp_pkg::NIB_W-1:0]   timer_ctrl_three,
    output logic      [atp_pkg::NIB_W-1:0]   timer_ctrl_four,
    output logic      [atp_pkg::NIB_W-1:0]   timer_ctrl_five,
    output logic      [atp_pkg::NIB_W-1:0]   timer_ctrl_six,
    output logic      [atp_pkg::N_TGT-1:0]   tgt_wr_stb,
    output logic                             carry_write,
    output logic                             skip_next
);

    // =========================================================
    // decode
    logic [atp_pkg::N_TGT-1:0] tgt_sel;
    logic                      en_ff;
    logic                      nxt_en;

    atp_decode
    #(
        .OP_INT_CTRL_TWO   (OP_INT_CTRL_TWO),
        .OP_TIMER_CTRL_THR (OP_TIMER_CTRL_THR),
        .OP_TIMER_CTRL_FIV (OP_TIMER_CTRL_FIV)
    )
    u_dec
    (
        .instr_word  (instr_word),
        .instr_valid (instr_valid & en_ff),
        .tgt_sel     (tgt_sel)
    );

    // =========================================================
    // target registers
    logic [atp_pkg::BYTE_W-1:0] tgt_ff  [atp_pkg::N_TGT];
    logic [atp_pkg::BYTE_W-1:0] nxt_tgt [atp_pkg::N_TGT];
    logic [atp_pkg::N_TGT-1:0]  stb_ff;
    logic                       carry_we_ff;
    logic                       skip_ff;
    logic [atp_pkg::IDX_W-1:0]  last_ff;
    logic [atp_pkg::IDX_W-1:0]  nxt_last;
    logic [atp_pkg::CNT_W-1:0]  cnt_ff;
    logic [atp_pkg::CNT_W-1:0]  nxt_cnt;
    logic                       seen_ff;
    logic                       nxt_seen;
    logic                       clr_stat;

    always_comb
    begin
        for (int i = 0; i < atp_pkg::N_TGT; i++)
        begin
            nxt_tgt[i] = tgt_ff[i];
        end
        nxt_last = last_ff;
        nxt_seen = seen_ff;
        nxt_cnt  = clr_stat ? '0 : cnt_ff;
        if (tgt_sel[atp_pkg::T_TIMER3_RELOAD])
            nxt_tgt[atp_pkg::T_TIMER3_RELOAD] = {breg, acc};                   // [RULE_01]
        if (tgt_sel[atp_pkg::T_CLOCK_GEN])
            nxt_tgt[atp_pkg::T_CLOCK_GEN] = {7'h00, acc[0]};                   // [RULE_02]
        if (tgt_sel[atp_pkg::T_SERIAL_SHIFT])
            nxt_tgt[atp_pkg::T_SERIAL_SHIFT] = {breg, acc};                    // [RULE_03]
        if (tgt_sel[atp_pkg::T_INT_CTRL_ONE])
            nxt_tgt[atp_pkg::T_INT_CTRL_ONE] = {4'h0, acc};                    // [RULE_04]
        if (tgt_sel[atp_pkg::T_INT_CTRL_TWO])
            nxt_tgt[atp_pkg::T_INT_CTRL_TWO] = {4'h0, acc};                    // [RULE_05]
        if (tgt_sel[atp_pkg::T_TIMER_CTRL_1])
            nxt_tgt[atp_pkg::T_TIMER_CTRL_1] = {4'h0, acc};                    // [RULE_06]
        if (tgt_sel[atp_pkg::T_TIMER_CTRL_2])
            nxt_tgt[atp_pkg::T_TIMER_CTRL_2] = {4'h0, acc};                    // [RULE_07]
        if (tgt_sel[atp_pkg::T_TIMER_CTRL_3])
            nxt_tgt[atp_pkg::T_TIMER_CTRL_3] = {4'h0, acc};                    // [RULE_08]
        if (tgt_sel[atp_pkg::T_TIMER_CTRL_4])
            nxt_tgt[atp_pkg::T_TIMER_CTRL_4] = {4'h0, acc};                    // [RULE_09]
        if (tgt_sel[atp_pkg::T_TIMER_CTRL_5])
            nxt_tgt[atp_pkg::T_TIMER_CTRL_5] = {4'h0, acc};                    // [RULE_10]
        if (tgt_sel[atp_pkg::T_TIMER_CTRL_6])
            nxt_tgt[atp_pkg::T_TIMER_CTRL_6] = {4'h0, acc};                    // [RULE_11]
        for (int i = 0; i < atp_pkg::N_TGT; i++)
        begin
            if (tgt_sel[i])
            begin
                nxt_last = atp_pkg::IDX_W'(i);
                nxt_seen = 1'b1;
            end
        end
        // a transfer in the clearing cycle still counts
        if (|tgt_sel)
            nxt_cnt = nxt_cnt + 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < atp_pkg::N_TGT; i++)
            begin
                tgt_ff[i] <= atp_pkg::TGT_RST;
            end
            stb_ff      <= '0;
            carry_we_ff <= 1'b0;
            skip_ff     <= 1'b0;
            last_ff     <= '0;
            cnt_ff      <= '0;
            seen_ff     <= 1'b0;
        end
        else
        begin
            tgt_ff      <= nxt_tgt;
            stb_ff      <= tgt_sel;
            // transfers never touch carry nor skip; acc and breg are only read
            carry_we_ff <= 1'b0;                                               // [RULE_12]
            skip_ff     <= 1'b0;                                               // [RULE_12]
            last_ff     <= nxt_last;
            cnt_ff      <= nxt_cnt;
            seen_ff     <= nxt_seen;
        end
    end

    assign timer_three_reload = tgt_ff[atp_pkg::T_TIMER3_RELOAD];
    assign clock_gen_ctrl     = tgt_ff[atp_pkg::T_CLOCK_GEN][0];
    assign serial_shift       = tgt_ff[atp_pkg::T_SERIAL_SHIFT];
    assign int_ctrl_one       = tgt_ff[atp_pkg::T_INT_CTRL_ONE][atp_pkg::NIB_W-1:0];
    assign int_ctrl_two       = tgt_ff[atp_pkg::T_INT_CTRL_TWO][atp_pkg::NIB_W-1:0];
    assign timer_ctrl_one     = tgt_ff[atp_pkg::T_TIMER_CTRL_1][atp_pkg::NIB_W-1:0];
    assign timer_ctrl_two     = tgt_ff[atp_pkg::T_TIMER_CTRL_2][atp_pkg::NIB_W-1:0];
    assign timer_ctrl_three   = tgt_ff[atp_pkg::T_TIMER_CTRL_3][atp_pkg::NIB_W-1:0];
    assign timer_ctrl_four    = tgt_ff[atp_pkg::T_TIMER_CTRL_4][atp_pkg::NIB_W-1:0];
    assign timer_ctrl_five    = tgt_ff[atp_pkg::T_TIMER_CTRL_5][atp_pkg::NIB_W-1:0];
    assign timer_ctrl_six     = tgt_ff[atp_pkg::T_TIMER_CTRL_6][atp_pkg::NIB_W-1:0];
    assign tgt_wr_stb         = stb_ff;
    assign carry_write        = carry_we_ff;
    assign skip_next          = skip_ff;

    // =========================================================
    // apb slave
    logic                        pready_ff;
    logic                        nxt_pready;
    logic                        pslverr_ff;
    logic                        nxt_pslverr;
    logic [atp_pkg::DATA_W-1:0]  prdata_ff;
    logic [atp_pkg::DATA_W-1:0]  nxt_prdata;
    logic                        acc_done;
    logic                        hit_ok;
    logic [atp_pkg::DATA_W-1:0]  rd_val;

    function automatic logic tgt_hit(input logic [atp_pkg::ADDR_W-1:0] a);
        tgt_hit = (a >= atp_pkg::ADDR_TGT_BASE) && (a[1:0] == 2'h0)
                  && (((a - atp_pkg::ADDR_TGT_BASE) >> 2) < atp_pkg::ADDR_W'(atp_pkg::N_TGT));
    endfunction

    always_comb
    begin
        acc_done = psel && penable && !pready_ff;
        hit_ok   = (paddr == atp_pkg::ADDR_CTRL) || (paddr == atp_pkg::ADDR_STATUS) || tgt_hit(paddr);
        rd_val   = '0;
        if (paddr == atp_pkg::ADDR_CTRL)
            rd_val[atp_pkg::CTRL_EN_BIT] = en_ff;
        else if (paddr == atp_pkg::ADDR_STATUS)
        begin
            rd_val[atp_pkg::IDX_W-1:0]                          = last_ff;
            rd_val[atp_pkg::STAT_CNT_LSB +: atp_pkg::CNT_W]     = cnt_ff;
            rd_val[atp_pkg::STAT_VLD_BIT]                       = seen_ff;
        end
        else if (tgt_hit(paddr))
            rd_val[atp_pkg::BYTE_W-1:0] = tgt_ff[IDX_W_CAST(paddr)];
        nxt_pready  = acc_done;
        nxt_pslverr = acc_done && !hit_ok;
        nxt_prdata  = (acc_done && !pwrite && hit_ok) ? rd_val : prdata_ff;
        nxt_en      = en_ff;
        clr_stat    = 1'b0;
        // writes commit on the edge where the master sees pready high
        if (psel && penable && pready_ff && pwrite && (paddr == atp_pkg::ADDR_CTRL))
            nxt_en = pwdata[atp_pkg::CTRL_EN_BIT];
        if (psel && penable && pready_ff && pwrite && (paddr == atp_pkg::ADDR_STATUS))
            clr_stat = 1'b1;
    end

    function automatic logic [atp_pkg::IDX_W-1:0] IDX_W_CAST(input logic [atp_pkg::ADDR_W-1:0] a);
        logic [atp_pkg::ADDR_W-1:0] d;
        d          = (a - atp_pkg::ADDR_TGT_BASE) >> 2;
        IDX_W_CAST = d[atp_pkg::IDX_W-1:0];
    endfunction

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
            en_ff      <= atp_pkg::CTRL_EN_RST;
        end
        else
        begin
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff  <= nxt_prdata;
            en_ff      <= nxt_en;
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;

endmodule

// >>> verif/atp_xfer_sva.sv
`timescale 1ns/100ps
module atp_xfer_sva
#(
    parameter logic [atp_pkg::OP_W-1:0] OP_INT_CTRL_TWO = 10'h03E
)
(
    input wire logic                        mclk,
    input wire logic                        rstn,
    input wire logic [atp_pkg::OP_W-1:0]    instr_word,
    input wire logic                        instr_valid,
    input wire logic [atp_pkg::NIB_W-1:0]   acc,
    input wire logic [atp_pkg::NIB_W-1:0]   breg,
    input wire logic [atp_pkg::BYTE_W-1:0]  timer_three_reload,
    input wire logic                        clock_gen_ctrl,
    input wire logic [atp_pkg::BYTE_W-1:0]  serial_shift,
    input wire logic [atp_pkg::NIB_W-1:0]   int_ctrl_one,
    input wire logic [atp_pkg::NIB_W-1:0]   int_ctrl_two,
    input wire logic [atp_pkg::NIB_W-1:0]   timer_ctrl_one,
    input wire logic [atp_pkg::NIB_W-1:0]   timer_ctrl_six,
    input wire logic [atp_pkg::N_TGT-1:0]   tgt_wr_stb,
    input wire logic                        carry_write,
    input wire logic                        skip_next
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    // ============================================================
    // opcode presented, then its target strobe one cycle later
    sequence s_take(logic [atp_pkg::OP_W-1:0] op);
        instr_valid && instr_word == op;
    endsequence
    sequence s_hit(logic [atp_pkg::OP_W-1:0] op, int k);
        s_take(op) ##1 tgt_wr_stb[k];
    endsequence

    // ============================================================
    // target contents follow the sources of the taken opcode; transfers leave carry and skip low
    a_reload_pair: assert property (
        s_hit(atp_pkg::LOAD_TIMER3_RELOAD_OP, 0) |-> timer_three_reload == $past({breg, acc}))
        else $error("reload register content wrong");
    a_clkgen_bit: assert property (
        s_take(atp_pkg::LOAD_CLOCK_GEN_OP) |=> tgt_wr_stb[1] && clock_gen_ctrl == $past(acc[0]))
        else $error("clock generator bit wrong");
    a_serial_pair: assert property (
        s_hit(atp_pkg::LOAD_SERIAL_SHIFT_OP, 2) |-> serial_shift == $past({breg, acc}))
        else $error("serial shift content wrong");
    a_int_one_load: assert property (
        s_take(atp_pkg::LOAD_INT_CTRL_ONE_OP) |=> tgt_wr_stb[3] && int_ctrl_one == $past(acc))
        else $error("interrupt control one wrong");
    a_int_two_load: assert property (
        s_hit(OP_INT_CTRL_TWO, 4) |-> int_ctrl_two == $past(acc))
        else $error("interrupt control two wrong");
    a_tctrl_one_load: assert property (
        s_take(atp_pkg::LOAD_TIMER_CTRL_ONE_OP) |=> tgt_wr_stb[5] && timer_ctrl_one == $past(acc))
        else $error("timer control one wrong");
    a_tctrl_six_load: assert property (
        s_hit(atp_pkg::LOAD_TIMER_CTRL_SIX_OP, 10) |-> timer_ctrl_six == $past(acc))
        else $error("timer control six wrong");
    a_no_side_eff: assert property (
        instr_valid |=> (!carry_write && !skip_next) [*2])
        else $error("transfer touched carry or skip");
endmodule

bind atp_xfer_top atp_xfer_sva #(.OP_INT_CTRL_TWO(OP_INT_CTRL_TWO)) u_atp_xfer_sva (
    .mclk, .rstn, .instr_word, .instr_valid, .acc, .breg, .timer_three_reload, .clock_gen_ctrl,
    .serial_shift, .int_ctrl_one, .int_ctrl_two, .timer_ctrl_one, .timer_ctrl_six, .tgt_wr_stb,
    .carry_write, .skip_next);

// >>> verif/test_accumulator_to_peripheral_transfer.sv
`timescale 1ns/100ps
module test_accumulator_to_peripheral_transfer;
    logic        mclk, rstn, instr_valid, psel, penable, pwrite, pready, pslverr, clock_gen_ctrl;
    logic        carry_write, skip_next;
    logic [9:0]  instr_word;
    logic [3:0]  acc, breg, int_ctrl_one, int_ctrl_two, timer_ctrl_one, timer_ctrl_two;
    logic [3:0]  timer_ctrl_three, timer_ctrl_four, timer_ctrl_five, timer_ctrl_six;
    logic [7:0]  paddr, timer_three_reload, serial_shift;
    logic [31:0] pwdata, prdata;
    logic [10:0] tgt_wr_stb;
    logic [7:0]  tv [0:10];
    logic [9:0]  ops [0:10];
    int          failures, n_checks;

    atp_xfer_top u_atp_xfer_top (.mclk, .rstn, .instr_word, .instr_valid, .acc, .breg, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_three_reload, .clock_gen_ctrl,
        .serial_shift, .int_ctrl_one, .int_ctrl_two, .timer_ctrl_one, .timer_ctrl_two, .timer_ctrl_three,
        .timer_ctrl_four, .timer_ctrl_five, .timer_ctrl_six, .tgt_wr_stb, .carry_write, .skip_next);

    assign tv = '{timer_three_reload, {7'h00, clock_gen_ctrl}, serial_shift, {4'h0, int_ctrl_one},
        {4'h0, int_ctrl_two}, {4'h0, timer_ctrl_one}, {4'h0, timer_ctrl_two}, {4'h0, timer_ctrl_three},
        {4'h0, timer_ctrl_four}, {4'h0, timer_ctrl_five}, {4'h0, timer_ctrl_six}};

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ============================================================
    // shared helpers
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int k;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        penable <= 1'b0;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge mclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
        if (k >= 20)
        begin
            failures++;
            print_verdict();
        end
    endtask

    task automatic issue(input logic [9:0] op, input logic [3:0] a, input logic [3:0] b);
        instr_valid <= 1'b1;
        instr_word  <= op;
        acc         <= a;
        breg        <= b;
        @(posedge mclk);
        instr_valid <= 1'b0;
    endtask

    function automatic logic [31:0] exp_val(int i, logic [3:0] a, logic [3:0] b);
        if (i == 0 || i == 2)
            return {24'h000000, b, a};
        if (i == 1)
            return {31'h00000000, a[0]};
        return {28'h0000000, a};
    endfunction

    // ============================================================
    // scenarios
    task automatic s_reset();
        logic [31:0] r;
        logic        e;
        rstn <= 1'b0;
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        for (int i = 0; i < 11; i++)
            chk("target_reset", 32'h00000000, {24'h000000, tv[i]});
        apb(1'b0, atp_pkg::ADDR_CTRL, 32'h00000000, r, e);
        chk("ctrl_reset", 32'h00000001, r);
        apb(1'b0, atp_pkg::ADDR_STATUS, 32'h00000000, r, e);
        chk("status_reset", 32'h00000000, r);
    endtask

    task automatic s_all();
        logic [31:0] r;
        logic        e;
        logic [3:0]  a, b;
        for (int i = 0; i < 11; i++)
        begin
            a = 4'(3 * i + 4);
            b = 4'(9 - i);
            issue(ops[i], a, b);
            #1;
            chk("target", exp_val(i, a, b), {24'h000000, tv[i]});
            chk("strobe", 32'(11'h001 << i), {21'h000000, tgt_wr_stb});
            chk("carry_skip", 32'h00000000, {30'h00000000, carry_write, skip_next});
            @(posedge mclk);
            apb(1'b0, 8'(8 + 4 * i), 32'h00000000, r, e);
            chk("target_reg", exp_val(i, a, b), r);
        end
    endtask

    task automatic s_b2b();
        instr_valid <= 1'b1;
        instr_word  <= atp_pkg::LOAD_INT_CTRL_ONE_OP;
        acc         <= 4'hA;
        @(posedge mclk);
        instr_word  <= 10'h03E;
        acc         <= 4'h5;
        @(posedge mclk);
        instr_word  <= 10'h23A;
        acc         <= 4'hC;
        @(posedge mclk);
        instr_valid <= 1'b0;
        #1;
        chk("int_one", 32'h0000000A, {28'h0000000, int_ctrl_one});
        chk("int_two", 32'h00000005, {28'h0000000, int_ctrl_two});
        chk("junk_strobe", 32'h00000000, {21'h000000, tgt_wr_stb});
        chk("serial_kept", 32'h0000007A, {24'h000000, serial_shift});
        @(posedge mclk);
    endtask

    task automatic s_enable();
        logic [31:0] r;
        logic        e;
        apb(1'b1, atp_pkg::ADDR_CTRL, 32'h00000000, r, e);
        issue(atp_pkg::LOAD_TIMER_CTRL_TWO_OP, 4'h9, 4'h1);
        #1;
        chk("disabled_kept", 32'h00000006, {28'h0000000, timer_ctrl_two});
        @(posedge mclk);
        apb(1'b1, atp_pkg::ADDR_STATUS, 32'h00000000, r, e);
        apb(1'b1, atp_pkg::ADDR_CTRL, 32'h00000001, r, e);
        issue(atp_pkg::LOAD_TIMER_CTRL_SIX_OP, 4'h6, 4'h1);
        apb(1'b0, atp_pkg::ADDR_STATUS, 32'h00000000, r, e);
        chk("status", 32'h8000010A, r);
        chk("tctrl_six", 32'h00000006, {28'h0000000, timer_ctrl_six});
        apb(1'b0, 8'h40, 32'h00000000, r, e);
        chk("unmapped_err", 32'h00000001, {31'h00000000, e});
        apb(1'b1, 8'h14, 32'h000000FF, r, e);
        chk("ro_write_err", 32'h00000000, {31'h00000000, e});
        apb(1'b0, 8'h14, 32'h00000000, r, e);
        chk("ro_kept", 32'h0000000A, r);
    endtask

    initial
    begin
        failures    = 0;
        n_checks    = 0;
        rstn        = 1'b0;
        instr_valid = 1'b0;
        instr_word  = 10'h000;
        acc         = 4'h0;
        breg        = 4'h0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 8'h00;
        pwdata      = 32'h00000000;
        ops = '{atp_pkg::LOAD_TIMER3_RELOAD_OP, atp_pkg::LOAD_CLOCK_GEN_OP, atp_pkg::LOAD_SERIAL_SHIFT_OP,
            atp_pkg::LOAD_INT_CTRL_ONE_OP, 10'h03E, atp_pkg::LOAD_TIMER_CTRL_ONE_OP,
            atp_pkg::LOAD_TIMER_CTRL_TWO_OP, 10'h210, atp_pkg::LOAD_TIMER_CTRL_FOUR_OP, 10'h212,
            atp_pkg::LOAD_TIMER_CTRL_SIX_OP};
        s_reset();
        s_all();
        s_b2b();
        s_enable();
        s_reset();
        print_verdict();
    end
endmodule
